// file: hdl/dac_ctrl_pkg.sv
// Purpose: shared constants and types of the DAC host interface control block
// Assumes: mclk at 250 MHz
// Notes: times are kept in their printed unit; cycle counts are derived from them
`default_nettype none
package dac_ctrl_pkg;
	localparam int MCLK_PERIOD_NS = 4;
	localparam int RESET_TIME_US = 270;
	localparam int CLEAR_TIME_US = 35;
	localparam int RESET_CYCLES_DEF = (RESET_TIME_US * 1000 + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
	localparam int CLEAR_CYCLES_DEF = (CLEAR_TIME_US * 1000 + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
	localparam int CALC_CYCLES = 8;
	localparam int CHANNELS = 40;
	localparam int GROUPS = 5;
	localparam int GROUP_SIZE = 8;
	localparam int FRAME_BITS = 24;
	localparam int QUEUE_DEPTH = 128;
	// frame field positions, msb first on the wire
	localparam int POS_BANK = 23;
	localparam int POS_RW = 22;
	localparam int POS_ADDR = 16;
	localparam int POS_REG = 14;
	localparam int POS_DATA = 2;
	// register_select codes
	localparam logic [1:0] SEL_SPECIAL = 2'h0;
	localparam logic [1:0] SEL_GAIN = 2'h1;
	localparam logic [1:0] SEL_OFFSET = 2'h2;
	localparam logic [1:0] SEL_INPUT = 2'h3;
	localparam logic [5:0] CLEAR_CODE_ADDR = 6'h02;
	// reset values
	localparam logic [11:0] GAIN_RESET = 12'hfff;
	localparam logic [11:0] OFFSET_RESET = 12'h800;
	localparam logic [11:0] ZERO_CODE = 12'h000;
	localparam logic [11:0] OFFSET_MID = 12'h800;
	typedef struct packed {
		logic bank;
		logic [5:0] addr;
		logic [1:0] sel;
		logic [11:0] data;
	} cmd_type;
endpackage
`default_nettype wire

// file: hdl/dac_host_interface_control.sv
// Purpose: host-side control of a 40-channel DAC: reset, clear, busy, load strobe, queue, serial frames
// Assumes: all pins are asynchronous to mclk; reset, clear, load, write, queue enable and serial pins pass two flops first
// Notes: corrected_value = input_value*(gain+1)/4096 + offset - 2048, clamped to 12 bits
// Overview of operation
// - reset pin falling edge restores defaults, zeroes DAC codes, lasts 270 us
// - while reset runs, interfaces are off and load strobes are dropped
// - after reset, normal work resumes; reset level ignored until next falling edge
// - clear pin low loads every DAC code from the clear register within 35 us
// - each value write recomputes corrected value, busy low, writes still accepted
// - a load strobe during busy outside reset and clear is remembered and applied when busy ends
// - outside enabled toggle groups, load copies only channels with a gain, offset or input write since last load
// - queue enable is sampled at power-up, clear and reset; queue used in parallel only
// - queue holds 128 instructions, writes arriving while full are dropped
// - busy stays low while queued instructions execute; host may keep writing
// - power-on sets defaults, outputs high impedance, busy low blocks writes
// - serial_parallel_select picks interface; serial_protocol_select high turns the serial interface off
// - frame: bank, read/write, 6 address, 2 select, 12 data, 2 spare bits
// - standalone: frame_sync_n fall starts frame; after 24 bits clock is ignored
// - daisy chain shifts while frame_sync_n low, overflow leaves on serial_out
// - host gives 24 clocks per device; frame_sync_n rise latches the frame
// - frame_sync_n rising before 24 clocks discards the frame
// - read frame selects a register, shifted out during the next frame
// - readback word holds previous address bits on top and register data below
// - with clock idling high, first readback bit appears at frame_sync_n fall
// - toggle groups swap between A and B codes on each load strobe
`timescale 1ns/100ps
`default_nettype none
module dac_host_interface_control #(
	parameter int RESET_CYCLES = dac_ctrl_pkg::RESET_CYCLES_DEF,
	parameter int CLEAR_CYCLES = dac_ctrl_pkg::CLEAR_CYCLES_DEF
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic reset_n,
	input wire logic clear_input_n,
	input wire logic load_dac_strobe_n,
	input wire logic queue_enable,
	input wire logic serial_parallel_select,
	input wire logic serial_protocol_select,
	input wire logic chain_enable,
	input wire logic [4:0] toggle_group_enables,
	input wire logic frame_sync_n,
	input wire logic sclk,
	input wire logic sdin,
	input wire logic par_write_n,
	input wire logic par_bank,
	input wire logic [5:0] par_addr,
	input wire logic [1:0] par_sel,
	input wire logic [11:0] par_data,
	output logic serial_out,
	output logic busy_n,
	output logic outputs_hiz,
	output logic [dac_ctrl_pkg::CHANNELS*12-1:0] dac_codes
);
	import dac_ctrl_pkg::*;
	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_RESET = 4'h2,
		ST_CLEAR = 4'h4,
		ST_SPARE = 4'h8
	} state_type;
	typedef struct packed {
		state_type state;
		logic [16:0] cnt;
		logic [3:0] calc;
		logic por;
		logic [2:0] rs;
		logic [2:0] cs;
		logic [2:0] ls;
		logic [2:0] ws;
		logic [1:0] qs;
		logic deep;
		logic load_pend;
		logic [11:0] clr_code;
		logic [23:0] rb;
		logic [4:0] tsel;
		logic [CHANNELS-1:0] dirty;
		logic [CHANNELS-1:0][11:0] in_a;
		logic [CHANNELS-1:0][11:0] in_b;
		logic [CHANNELS-1:0][11:0] gain;
		logic [CHANNELS-1:0][11:0] offs;
		logic [CHANNELS-1:0][11:0] corr_a;
		logic [CHANNELS-1:0][11:0] corr_b;
		logic [CHANNELS-1:0][11:0] dac;
	} core_state_type;
	core_state_type st_reg, st_next;
	frame_link_type fl();
	queue_link_type ql();
	logic rst_fall, clr_fall, ld_fall, wr_rise, serial_on, busy, blocked;
	cmd_type cmd;
	logic cmd_valid;

	// corrected value from the three per-channel terms, saturated
	function automatic logic [11:0] calc_corr(input logic [11:0] x, input logic [11:0] m, input logic [11:0] c);
		logic [24:0] p;
		logic signed [14:0] s;
		p = 25'(x) * (25'(m) + 25'h1);
		s = $signed({2'b00, p[24:12]}) + $signed({3'b000, c}) - $signed({3'b000, OFFSET_MID});
		if (s < 0) begin
			return ZERO_CODE;
		end
		if (s > 15'sh0fff) begin
			return 12'hfff;
		end
		return s[11:0];
	endfunction

	// readback selection of one register
	function automatic logic [11:0] read_reg(input core_state_type s, input logic [5:0] a, input logic [1:0] r, input logic b);
		if (r == SEL_SPECIAL) begin
			return (a == CLEAR_CODE_ADDR) ? s.clr_code : ZERO_CODE;
		end
		if (a >= 6'(CHANNELS)) begin
			return ZERO_CODE;
		end
		unique case (r)
			SEL_GAIN: return s.gain[a];
			SEL_OFFSET: return s.offs[a];
			default: return b ? s.in_b[a] : s.in_a[a];
		endcase
	endfunction

	serial_frame_rx u_rx (
		.mclk(mclk),
		.rst(rst),
		.chain_enable(chain_enable),
		.frame_sync_n(frame_sync_n),
		.sclk(sclk),
		.sdin(sdin),
		.serial_out(serial_out),
		.link(fl.rx)
	);

	instr_queue u_queue (
		.mclk(mclk),
		.rst(rst),
		.q(ql.fifo)
	);

	// pin edges, taken after the two synchroniser flops
	assign rst_fall = st_reg.rs[2] & ~st_reg.rs[1];
	assign clr_fall = st_reg.cs[2] & ~st_reg.cs[1];
	assign ld_fall = st_reg.ls[2] & ~st_reg.ls[1];
	assign wr_rise = ~st_reg.ws[2] & st_reg.ws[1];
	assign blocked = st_reg.state != ST_IDLE;
	assign busy = blocked || st_reg.calc != 4'h0 || ql.pop_valid;
	assign serial_on = serial_parallel_select && !serial_protocol_select;

	// interface hookup
	assign fl.enable = serial_on && !blocked;
	assign fl.rb_word = st_reg.rb;
	assign ql.flush = blocked;
	assign ql.deep = st_reg.deep;
	assign ql.push_valid = wr_rise && !serial_parallel_select && !blocked;
	assign ql.push_data = '{bank: par_bank, addr: par_addr, sel: par_sel, data: par_data};
	assign ql.pop_ready = !blocked && st_reg.calc == 4'h0;

	// one command per cycle from whichever interface is selected
	always_comb begin
		cmd = ql.pop_data;
		cmd_valid = ql.pop_valid && ql.pop_ready;
		if (serial_on) begin
			cmd.bank = fl.frame_word[POS_BANK];
			cmd.addr = fl.frame_word[POS_ADDR +: 6];
			cmd.sel = fl.frame_word[POS_REG +: 2];
			cmd.data = fl.frame_word[POS_DATA +: 12];
			cmd_valid = fl.frame_valid && !blocked && !fl.frame_word[POS_RW];
		end
	end

	// main sequencing
	always_comb begin
		logic [11:0] xa;
		logic [11:0] xb;
		logic [11:0] xm;
		logic [11:0] xc;
		logic [2:0] g;
		xa = ZERO_CODE;
		xb = ZERO_CODE;
		xm = ZERO_CODE;
		xc = ZERO_CODE;
		g = 3'h0;
		st_next = st_reg;
		st_next.rs = {st_reg.rs[1:0], reset_n};
		st_next.cs = {st_reg.cs[1:0], clear_input_n};
		st_next.ls = {st_reg.ls[1:0], load_dac_strobe_n};
		st_next.ws = {st_reg.ws[1:0], par_write_n};
		st_next.qs = {st_reg.qs[0], queue_enable};
		if (st_reg.calc != 4'h0) begin
			st_next.calc = st_reg.calc - 4'h1;
		end
		unique case (st_reg.state)
			ST_RESET: begin
				st_next.load_pend = 1'b0;
				if (st_reg.cnt == 17'h0) begin
					st_next.state = ST_IDLE;
					st_next.por = 1'b0;
					st_next.deep = st_reg.qs[1] && !serial_parallel_select;
				end else begin
					st_next.cnt = st_reg.cnt - 17'h1;
				end
			end
			ST_CLEAR: begin
				st_next.load_pend = 1'b0;
				if (st_reg.cnt == 17'h0) begin
					st_next.state = ST_IDLE;
					st_next.deep = st_reg.qs[1] && !serial_parallel_select;
				end else begin
					st_next.cnt = st_reg.cnt - 17'h1;
				end
			end
			default: begin
				if (cmd_valid) begin
					if (cmd.sel == SEL_SPECIAL) begin
						if (cmd.addr == CLEAR_CODE_ADDR) begin
							st_next.clr_code = cmd.data;
						end
					end else if (cmd.addr < 6'(CHANNELS)) begin
						xa = st_reg.in_a[cmd.addr];
						xb = st_reg.in_b[cmd.addr];
						xm = st_reg.gain[cmd.addr];
						xc = st_reg.offs[cmd.addr];
						unique case (cmd.sel)
							SEL_GAIN: xm = cmd.data;
							SEL_OFFSET: xc = cmd.data;
							default: begin
								if (cmd.bank) begin
									xb = cmd.data;
								end else begin
									xa = cmd.data;
								end
							end
						endcase
						st_next.in_a[cmd.addr] = xa;
						st_next.in_b[cmd.addr] = xb;
						st_next.gain[cmd.addr] = xm;
						st_next.offs[cmd.addr] = xc;
						st_next.corr_a[cmd.addr] = calc_corr(xa, xm, xc);
						st_next.corr_b[cmd.addr] = calc_corr(xb, xm, xc);
						st_next.dirty[cmd.addr] = 1'b1;
						st_next.calc = 4'(CALC_CYCLES);
					end
				end
				// a read frame arms the word shifted out in the next frame
				if (serial_on && fl.frame_valid && fl.frame_word[POS_RW]) begin
					st_next.rb = {fl.frame_word[23:14], read_reg(st_reg, fl.frame_word[POS_ADDR +: 6],
						fl.frame_word[POS_REG +: 2], fl.frame_word[POS_BANK]), 2'b00};
				end
				// load strobe: stored while busy, applied once busy ends
				if (ld_fall) begin
					st_next.load_pend = 1'b1;
				end
				if ((ld_fall || st_reg.load_pend) && !busy) begin
					st_next.load_pend = 1'b0;
					st_next.tsel = st_reg.tsel ^ toggle_group_enables;
					for (int i = 0; i < CHANNELS; i++) begin
						g = 3'(i / GROUP_SIZE);
						if (toggle_group_enables[g]) begin
							st_next.dac[i] = st_next.tsel[g] ? st_reg.corr_b[i] : st_reg.corr_a[i];
						end else if (st_reg.dirty[i]) begin
							st_next.dac[i] = st_reg.corr_a[i];
						end
					end
					st_next.dirty = '0;
				end
				if (clr_fall) begin
					st_next.state = ST_CLEAR;
					st_next.cnt = 17'(CLEAR_CYCLES - 1);
					for (int i = 0; i < CHANNELS; i++) begin
						st_next.dac[i] = st_reg.clr_code;
					end
				end
			end
		endcase
		// reset edge wins over everything, even during a clear
		if (rst_fall && st_reg.state != ST_RESET) begin
			st_next = '0;
			st_next.rs = {st_reg.rs[1:0], reset_n};
			st_next.cs = {st_reg.cs[1:0], clear_input_n};
			st_next.ls = {st_reg.ls[1:0], load_dac_strobe_n};
			st_next.ws = {st_reg.ws[1:0], par_write_n};
			st_next.qs = {st_reg.qs[0], queue_enable};
			st_next.state = ST_RESET;
			st_next.cnt = 17'(RESET_CYCLES - 1);
			for (int i = 0; i < CHANNELS; i++) begin
				st_next.gain[i] = GAIN_RESET;
				st_next.offs[i] = OFFSET_RESET;
				st_next.corr_a[i] = calc_corr(ZERO_CODE, GAIN_RESET, OFFSET_RESET);
				st_next.corr_b[i] = calc_corr(ZERO_CODE, GAIN_RESET, OFFSET_RESET);
			end
		end
	end

	// registered state; power-on runs the same sequence as a reset edge
	always_ff @(posedge mclk) begin
		if (rst) begin
			st_reg <= '0;
			st_reg.state <= ST_RESET;
			st_reg.cnt <= 17'(RESET_CYCLES - 1);
			st_reg.por <= 1'b1;
			st_reg.rs <= 3'h7;
			st_reg.cs <= 3'h7;
			st_reg.ls <= 3'h7;
			st_reg.ws <= 3'h7;
			for (int i = 0; i < CHANNELS; i++) begin
				st_reg.gain[i] <= GAIN_RESET;
				st_reg.offs[i] <= OFFSET_RESET;
			end
		end else begin
			st_reg <= st_next;
		end
	end

	assign busy_n = !busy;
	assign outputs_hiz = st_reg.por;
	assign dac_codes = st_reg.dac;

	// checks
	sequence s_reset_start;
		rst_fall && st_reg.state != ST_RESET;
	endsequence
	// only a strobe seen while idle is kept; reset and clear drop it on purpose
	sequence s_load_seen;
		ld_fall && busy && st_reg.state == ST_IDLE;
	endsequence
	a_reset_zero: assert property (@(posedge mclk) disable iff (rst)
		s_reset_start |=> (st_reg.state == ST_RESET && st_reg.dac == '0 && busy_n == 1'b0)) else $error("reset edge missed");
	a_reset_length: assert property (@(posedge mclk) disable iff (rst)
		(st_reg.state == ST_RESET && st_reg.cnt != 17'h0 && !rst_fall) |=> st_reg.state == ST_RESET) else $error("reset ended early");
	a_reset_blocks: assert property (@(posedge mclk) disable iff (rst)
		(st_reg.state == ST_RESET) |-> (!fl.enable && !ql.push_valid && !ql.pop_ready)) else $error("interface live in reset");
	a_reset_drop_load: assert property (@(posedge mclk) disable iff (rst)
		(st_reg.state == ST_RESET) |=> !st_reg.load_pend) else $error("load kept in reset");
	a_reset_resume: assert property (@(posedge mclk) disable iff (rst)
		(st_reg.state == ST_RESET && st_reg.cnt == 17'h0 && !rst_fall) |=> st_reg.state == ST_IDLE) else $error("no resume");
	a_clear_load: assert property (@(posedge mclk) disable iff (rst)
		(st_reg.state == ST_IDLE && clr_fall && !rst_fall) |=> (st_reg.state == ST_CLEAR
		&& st_reg.dac[0] == $past(st_reg.clr_code) && st_reg.dac[CHANNELS-1] == $past(st_reg.clr_code))) else $error("clear failed");
	a_calc_busy: assert property (@(posedge mclk) disable iff (rst)
		(cmd_valid && st_reg.state == ST_IDLE && !rst_fall && !clr_fall && cmd.sel != SEL_SPECIAL && cmd.addr < 6'(CHANNELS))
		|=> !busy_n [*8]) else $error("busy not held for calc");
	a_load_kept: assert property (@(posedge mclk) disable iff (rst)
		(s_load_seen ##1 (st_reg.state == ST_IDLE)) |-> st_reg.load_pend) else $error("load lost while busy");
	a_load_clean: assert property (@(posedge mclk) disable iff (rst)
		(st_reg.state == ST_IDLE && !busy && (ld_fall || st_reg.load_pend) && !clr_fall && !rst_fall
		&& !st_reg.dirty[0] && !toggle_group_enables[0]) |=> $stable(st_reg.dac[0])) else $error("clean channel updated");
	a_queue_busy: assert property (@(posedge mclk) disable iff (rst)
		ql.pop_valid |-> !busy_n) else $error("busy high with queued work");
	a_hiz_por: assert property (@(posedge mclk) disable iff (rst)
		outputs_hiz |-> (st_reg.state == ST_RESET && !busy_n)) else $error("high impedance outside power-on");
endmodule
`default_nettype wire

// file: hdl/dac_links_if.sv
// Purpose: carriers between the core and its serial receiver and instruction queue
// Assumes: all signals on mclk
// Notes: two interfaces in one file
`timescale 1ns/100ps
`default_nettype none
interface frame_link_type;
	import dac_ctrl_pkg::*;
	logic enable;
	logic frame_valid;
	logic [23:0] frame_word;
	logic [23:0] rb_word;
	modport rx(input enable, rb_word, output frame_valid, frame_word);
	modport core(output enable, rb_word, input frame_valid, frame_word);
endinterface

interface queue_link_type;
	import dac_ctrl_pkg::*;
	logic flush;
	logic deep;
	logic push_valid;
	logic push_ready;
	cmd_type push_data;
	logic pop_valid;
	logic pop_ready;
	cmd_type pop_data;
	modport fifo(input flush, deep, push_valid, push_data, pop_ready, output push_ready, pop_valid, pop_data);
	modport core(output flush, deep, push_valid, push_data, pop_ready, input push_ready, pop_valid, pop_data);
endinterface
`default_nettype wire

// file: hdl/instr_queue.sv
// Purpose: parallel-mode instruction queue
// Assumes: one push and one pop at most per cycle
// Notes: when the queue is off it holds a single entry, so a write arriving while that entry still waits is dropped
`timescale 1ns/100ps
`default_nettype none
module instr_queue (
	input wire logic mclk,
	input wire logic rst,
	queue_link_type.fifo q
);
	import dac_ctrl_pkg::*;
	typedef struct packed {
		logic [QUEUE_DEPTH-1:0][20:0] mem;
		logic [6:0] wr;
		logic [6:0] rd;
		logic [7:0] count;
	} q_state_type;
	q_state_type st_reg, st_next;
	logic full, do_push, do_pop;
	assign full = q.deep ? (st_reg.count == 8'(QUEUE_DEPTH)) : (st_reg.count != 8'h00);
	assign do_push = q.push_valid && !full;
	assign do_pop = q.pop_ready && st_reg.count != 8'h00;
	// pointer and storage update
	always_comb begin
		st_next = st_reg;
		if (do_push) begin
			st_next.mem[st_reg.wr] = q.push_data;
			st_next.wr = st_reg.wr + 7'h01;
		end
		if (do_pop) begin
			st_next.rd = st_reg.rd + 7'h01;
		end
		st_next.count = st_reg.count + 8'(do_push) - 8'(do_pop);
		if (q.flush) begin
			st_next.wr = 7'h00;
			st_next.rd = 7'h00;
			st_next.count = 8'h00;
		end
	end
	// registered state
	always_ff @(posedge mclk) begin
		if (rst) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end
	assign q.push_ready = !full;
	assign q.pop_valid = st_reg.count != 8'h00;
	assign q.pop_data = st_reg.mem[st_reg.rd];
	a_full_drop: assert property (@(posedge mclk) disable iff (rst)
		(full && q.push_valid && !q.pop_ready && !q.flush) |=> $stable(st_reg.count)) else $error("write into full queue");
endmodule
`default_nettype wire

// file: hdl/serial_frame_rx.sv
// Purpose: 24-bit serial frame receiver with daisy-chain and readback shift-out
// Assumes: frame_sync_n, sclk and sdin come from another domain
// Notes: data taken on the sclk falling edge, serial_out moves on the rising edge
`timescale 1ns/100ps
`default_nettype none
module serial_frame_rx (
	input wire logic mclk,
	input wire logic rst,
	input wire logic chain_enable,
	input wire logic frame_sync_n,
	input wire logic sclk,
	input wire logic sdin,
	output logic serial_out,
	frame_link_type.rx link
);
	import dac_ctrl_pkg::*;
	typedef struct packed {
		logic [2:0] fs;
		logic [2:0] ck;
		logic [1:0] dn;
		logic active;
		logic [5:0] cnt;
		logic [23:0] sh;
		logic out_bit;
		logic valid;
	} rx_state_type;
	rx_state_type st_reg, st_next;
	logic fs_fall, fs_rise, ck_fall, ck_rise;
	// edge finders look only at the second and third flops
	assign fs_fall = st_reg.fs[2] & ~st_reg.fs[1];
	assign fs_rise = ~st_reg.fs[2] & st_reg.fs[1];
	assign ck_fall = st_reg.ck[2] & ~st_reg.ck[1];
	assign ck_rise = ~st_reg.ck[2] & st_reg.ck[1];
	// frame sequencing
	always_comb begin
		st_next = st_reg;
		st_next.fs = {st_reg.fs[1:0], frame_sync_n};
		st_next.ck = {st_reg.ck[1:0], sclk};
		st_next.dn = {st_reg.dn[0], sdin};
		st_next.valid = 1'b0;
		if (fs_fall && link.enable) begin
			st_next.active = 1'b1;
			st_next.cnt = 6'h00;
			st_next.sh = link.rb_word;
			st_next.out_bit = link.rb_word[23];
		end else if (st_reg.active) begin
			if (fs_rise) begin
				// short frames are dropped without any update
				st_next.active = 1'b0;
				st_next.valid = chain_enable && (st_reg.cnt >= 6'(FRAME_BITS));
			end else if (ck_fall) begin
				st_next.sh = {st_reg.sh[22:0], st_reg.dn[1]};
				if (st_reg.cnt != 6'h3f) begin
					st_next.cnt = st_reg.cnt + 6'h01;
				end
				if (!chain_enable && st_reg.cnt == 6'(FRAME_BITS - 1)) begin
					st_next.active = 1'b0;
					st_next.valid = 1'b1;
				end
			end else if (ck_rise) begin
				st_next.out_bit = st_reg.sh[23];
			end
		end
	end
	// registered state
	always_ff @(posedge mclk) begin
		if (rst) begin
			st_reg <= '{fs: 3'h7, ck: 3'h7, default: '0};
		end else begin
			st_reg <= st_next;
		end
	end
	assign serial_out = st_reg.out_bit;
	assign link.frame_valid = st_reg.valid;
	assign link.frame_word = st_reg.sh;
	a_short_frame: assert property (@(posedge mclk) disable iff (rst)
		(st_reg.active && fs_rise && st_reg.cnt < 6'(FRAME_BITS)) |=> !st_reg.valid) else $error("short frame accepted");
endmodule
`default_nettype wire

// file: tb/dac_host_interface_control_tb_top.sv
// Purpose: self-checking bench of the DAC host interface control
// Assumes: reset and clear counts shortened to 40 and 20 cycles
// Notes: with default gain and offset the corrected value equals the input value
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, exp, got) begin num_checks++; if ((got) !== (exp)) begin n_fail++; \
	$display("unexpected %s exp %h got %h", nm, exp, got); end end
module dac_host_interface_control_tb_top;
	import dac_ctrl_pkg::*;
	logic mclk, rst, reset_n, clear_input_n, load_dac_strobe_n, queue_enable, serial_parallel_select;
	logic chain_enable, frame_sync_n, sclk, sdin, par_write_n, serial_out, busy_n, outputs_hiz, par_bank;
	logic [4:0] toggle_group_enables;
	logic [5:0] par_addr;
	logic [1:0] par_sel;
	logic [11:0] par_data;
	logic [CHANNELS*12-1:0] dac_codes;
	logic [23:0] rd, f;
	int n_fail = 0;
	int num_checks = 0;
	host_serial_model host (.frame_sync_n(frame_sync_n), .sclk(sclk), .sdin(sdin), .serial_out(serial_out));
	dac_host_interface_control #(.RESET_CYCLES(40), .CLEAR_CYCLES(20)) uut (.mclk(mclk), .rst(rst),
		.reset_n(reset_n), .clear_input_n(clear_input_n), .load_dac_strobe_n(load_dac_strobe_n),
		.queue_enable(queue_enable), .serial_parallel_select(serial_parallel_select),
		.serial_protocol_select(1'b0), .chain_enable(chain_enable), .toggle_group_enables(toggle_group_enables),
		.frame_sync_n(frame_sync_n), .sclk(sclk), .sdin(sdin), .par_write_n(par_write_n), .par_bank(par_bank),
		.par_addr(par_addr), .par_sel(par_sel), .par_data(par_data), .serial_out(serial_out),
		.busy_n(busy_n), .outputs_hiz(outputs_hiz), .dac_codes(dac_codes));
	function automatic logic [23:0] frame(input logic [5:0] a, input logic [1:0] s, input logic [11:0] d,
		input logic rw);
		return {1'b0, rw, a, s, d, 2'b00};
	endfunction
	function automatic logic [11:0] code(input int ch);
		return dac_codes[12*ch +: 12];
	endfunction
	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	// bounded wait so a stuck busy cannot hang the run
	task automatic wait_idle();
		for (int i = 0; i < 300 && busy_n !== 1'b1; i++) cyc(1);
		`CHK("busy_n idle", 1'b1, busy_n)
	endtask
	task automatic strobe();
		load_dac_strobe_n = 1'b0;
		cyc(4);
		load_dac_strobe_n = 1'b1;
		cyc(4);
	endtask
	task automatic t_write();
		host.send(frame(6'h00, SEL_INPUT, 12'h5a3, 1'b0), 24, rd);
		host.send(frame(6'h01, SEL_INPUT, 12'h3c4, 1'b0), 24, rd);
		wait_idle();
		`CHK("ch0 before load", 12'h000, code(0))
		strobe();
		`CHK("ch0", 12'h5a3, code(0))
		`CHK("ch1", 12'h3c4, code(1))
		$display("write test done");
	endtask
	task automatic t_chain();
		chain_enable = 1'b1;
		host.send(frame(6'h02, SEL_INPUT, 12'h777, 1'b0), 20, rd);
		cyc(20);
		strobe();
		`CHK("ch2 short frame", 12'h000, code(2))
		host.send(frame(6'h02, SEL_INPUT, 12'h777, 1'b0), 24, rd);
		wait_idle();
		strobe();
		`CHK("ch2 chain frame", 12'h777, code(2))
		chain_enable = 1'b0;
		$display("chain test done");
	endtask
	task automatic t_readback();
		f = frame(6'h00, SEL_INPUT, 12'h000, 1'b1);
		host.send(f, 24, rd);
		host.send(24'h000000, 24, rd);
		`CHK("readback word", {f[23:14], 12'h5a3, 2'b00}, rd)
		$display("readback test done");
	endtask
	task automatic t_clear();
		host.send(frame(CLEAR_CODE_ADDR, SEL_SPECIAL, 12'habc, 1'b0), 24, rd);
		wait_idle();
		clear_input_n = 1'b0;
		cyc(6);
		`CHK("ch0 clear", 12'habc, code(0))
		`CHK("ch39 clear", 12'habc, code(39))
		wait_idle();
		clear_input_n = 1'b1;
		cyc(4);
		strobe();
		`CHK("ch2 unwritten", 12'habc, code(2))
		$display("clear test done");
	endtask
	task automatic t_reset();
		serial_parallel_select = 1'b0;
		queue_enable = 1'b1;
		reset_n = 1'b0;
		cyc(5);
		`CHK("busy in reset", 1'b0, busy_n)
		`CHK("ch0 reset", 12'h000, code(0))
		strobe();
		wait_idle();
		cyc(10);
		`CHK("busy after reset", 1'b1, busy_n)
		`CHK("ch2 reset", 12'h000, code(2))
		reset_n = 1'b1;
		$display("reset test done");
	endtask
	// pushes 6 cycles apart outrun execution, so busy must still be low after the last push
	task automatic t_queue();
		for (int i = 0; i < 4; i++) begin
			par_addr = 6'(3 + i);
			par_sel = SEL_INPUT;
			par_data = 12'(12'h100 + i);
			par_write_n = 1'b0;
			cyc(1);
			par_write_n = 1'b1;
			cyc(5);
		end
		`CHK("busy queue", 1'b0, busy_n)
		load_dac_strobe_n = 1'b0;
		cyc(4);
		`CHK("ch3 during busy", 12'h000, code(3))
		load_dac_strobe_n = 1'b1;
		wait_idle();
		cyc(4);
		for (int i = 0; i < 4; i++) `CHK("queued ch", 12'(12'h100 + i), code(3 + i))
		$display("queue test done");
	endtask
	// group 0 toggles: first load shows the B code, the next one the A code again
	task automatic t_toggle();
		par_bank = 1'b1;
		par_addr = 6'h03;
		par_sel = SEL_INPUT;
		par_data = 12'h2aa;
		par_write_n = 1'b0;
		cyc(1);
		par_write_n = 1'b1;
		cyc(5);
		par_bank = 1'b0;
		wait_idle();
		toggle_group_enables = 5'h01;
		strobe();
		`CHK("ch3 bank b", 12'h2aa, code(3))
		`CHK("ch4 bank b", 12'h000, code(4))
		strobe();
		`CHK("ch3 bank a", 12'h100, code(3))
		toggle_group_enables = 5'h00;
		$display("toggle test done");
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end
	initial begin
		#100000;
		n_fail++;
		tally_and_finish();
	end
	initial begin
		{rst, reset_n, clear_input_n, load_dac_strobe_n, serial_parallel_select, par_write_n} = 6'h3f;
		{queue_enable, chain_enable, par_bank, toggle_group_enables, par_addr, par_sel, par_data} = '0;
		cyc(2);
		`CHK("hiz in reset", 1'b1, outputs_hiz)
		`CHK("busy in power-on", 1'b0, busy_n)
		rst = 1'b0;
		wait_idle();
		`CHK("hiz after", 1'b0, outputs_hiz)
		t_write();
		t_chain();
		t_readback();
		t_clear();
		t_reset();
		t_queue();
		t_toggle();
		tally_and_finish();
	end
endmodule
`default_nettype wire

// file: tb/host_serial_model.sv
// Purpose: host master on the 3/4-wire serial link
// Assumes: sclk idles high with a 64 ns period and runs only inside frames
// Notes: a released data line shows the inverse of its last bit
`timescale 1ns/100ps
`default_nettype none
module host_serial_model (
	output logic frame_sync_n,
	output logic sclk,
	output logic sdin,
	input wire logic serial_out
);
	initial begin
		frame_sync_n = 1'b1;
		sclk = 1'b1;
		sdin = 1'b0;
	end
	// n bits msb first; serial_out is caught just before each fall, where it is valid
	task automatic send(input logic [23:0] w, input int n, output logic [23:0] rd);
		rd = 24'h000000;
		frame_sync_n = 1'b0;
		for (int i = 0; i < n; i++) begin
			sdin = w[23-i];
			#32;
			rd = {rd[22:0], serial_out};
			sclk = 1'b0;
			#32;
			sclk = 1'b1;
		end
		#32;
		frame_sync_n = 1'b1;
		sdin = ~sdin;
		#64;
	endtask
endmodule
`default_nettype wire
